// ===== dv/ref_clock_source.sv
// Reference clock source model for one input pin
`timescale 1ns/10ps
`default_nettype none
module ref_clock_source #(
    parameter int HALF_NS = 40
) (
    // Control
    input wire logic run,
    // Pin
    output logic ref_out
);
    // ------------------------------------------------------------------
    // Toggle only while enabled
    // ------------------------------------------------------------------
    // A stopped source holds its level, which the block sees as missing edges
    initial ref_out = 1'b0;
    always begin
        wait (run);
        // Non-blocking so a toggle that lands on a clock edge is seen one edge later
        #(HALF_NS) ref_out <= ~ref_out;
    end
endmodule
`default_nettype wire

// ===== dv/ref_input_revalidation_test.sv
// Testbench for the two-input reference re-validation block
`timescale 1ns/10ps
`default_nettype none
module ref_input_revalidation_test;
    import revalidation_pkg::*;
    // ------------------------------------------------------------------
    // Stimulus, design and sources
    // ------------------------------------------------------------------
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic clk_en = 1'b1;
    logic [1:0] loss_event = 2'h0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata_q;
    logic [1:0] signal_loss_flag;
    logic [1:0] ref_clk_in;
    logic [1:0] run = 2'h0;
    logic [7:0] v;
    logic [7:0] need [4] = '{8'h02, 8'h10, 8'h20, 8'h40};
    logic [3:0] ra [4] = '{4'h0, 4'h1, 4'h2, 4'hF};
    logic [7:0] re [4] = '{8'h00, 8'h40, 8'h00, 8'h00};
    int n_mismatch = 0;
    int comparisons = 0;
    int cyc = 0;
    always #5 clock = ~clock;
    ref_input_revalidation uut (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en),
        .ref_clk_in(ref_clk_in), .loss_event(loss_event), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata_q(reg_rdata_q), .signal_loss_flag(signal_loss_flag));
    ref_clock_source src0 (.run(run[0]), .ref_out(ref_clk_in[0]));
    ref_clock_source src1 (.run(run[1]), .ref_out(ref_clk_in[1]));
    // ------------------------------------------------------------------
    // Access and checking tasks
    // ------------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    // Data are taken just after the edge that follows the read strobe
    task automatic rd(input logic [3:0] a);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 v = reg_rdata_q;
    endtask
    task automatic lose(input int i);
        @(posedge clock);
        loss_event[i] <= 1'b1;
        @(posedge clock);
        loss_event[i] <= 1'b0;
    endtask
    // Loss, then count clock cycles until the flag clears; one divided period of slack
    task automatic reval(input int i, input int code, input int div);
        int n;
        int p;
        p = 8 << div;
        n = 0;
        wr(CONFIG_OFFSET, 8'(div * 4 + code));
        lose(i);
        rd(COUNT0_OFFSET + 4'(i));
        chk("count load", v, need[code]);
        chk("flag set", 8'(signal_loss_flag[i]), 8'h01);
        rd(STATUS_OFFSET);
        chk("status", v, 8'h05 << i);
        run[i] <= 1'b1;
        // Look just after the edge so the flag has settled
        while (signal_loss_flag[i] !== 1'b0 && n < 20000) begin
            @(posedge clock);
            #1 n++;
        end
        chk("periods", 8'(n >= (need[code] - 1) * p && n <= (need[code] + 1) * p), 8'h01);
        repeat (20) @(posedge clock);
        rd(COUNT0_OFFSET + 4'(i));
        chk("count idle", v, 8'h00);
        chk("other flag", 8'(signal_loss_flag[1 - i]), 8'h00);
        run[i] <= 1'b0;
    endtask
    task automatic close_out;
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // Hang guard far above the roughly 1500 cycles the run needs
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_mismatch++;
            close_out();
        end
    end
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clock);
        sys_rst <= 1'b0;
        wr(STATUS_OFFSET, 8'hFF);
        for (int k = 0; k < 4; k++) begin
            rd(ra[k]);
            chk("reset value", v, re[k]);
        end
        // Wide window so slow divided periods are not taken as missing
        wr(WINDOW_OFFSET, 8'hFF);
        for (int c = 0; c < 4; c++) begin
            reval(0, c, 0);
        end
        reval(1, 0, 3);
        // Stop the pin mid-count: the count must return to its setting
        wr(WINDOW_OFFSET, 8'h20);
        wr(CONFIG_OFFSET, 8'h01);
        lose(0);
        run[0] <= 1'b1;
        repeat (40) @(posedge clock);
        run[0] <= 1'b0;
        rd(COUNT0_OFFSET);
        chk("count running", 8'(v < 8'h10 && v > 8'h0A), 8'h01);
        repeat (60) @(posedge clock);
        rd(COUNT0_OFFSET);
        chk("count reload", v, 8'h10);
        // Freeze the block while the pin runs: nothing may count
        @(posedge clock);
        clk_en <= 1'b0;
        run[0] <= 1'b1;
        repeat (100) @(posedge clock);
        run[0] <= 1'b0;
        repeat (12) @(posedge clock);
        clk_en <= 1'b1;
        rd(COUNT0_OFFSET);
        chk("count frozen", v, 8'h10);
        close_out();
    end
endmodule
bind ref_input_revalidation ref_reval_chk chk_i (.clock(clock), .sys_rst(sys_rst),
    .clk_en(clk_en), .loss_event(loss_event), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q), .signal_loss_flag(signal_loss_flag));
`default_nettype wire

// ===== dv/ref_reval_chk.sv
// Checker for the re-validation block port relations
`timescale 1ns/10ps
`default_nettype none
module ref_reval_chk
    import revalidation_pkg::*;
(
    // Clock and control
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clk_en,
    // Stimulus and answers
    input wire logic [NUM_INPUTS-1:0] loss_event,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata_q,
    input wire logic [NUM_INPUTS-1:0] signal_loss_flag
);
    // ------------------------------------------------------------------
    // Properties on the one clock domain
    // ------------------------------------------------------------------
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    // Loss raises the pin flag two edges later, on each input alone
    property p_load0; loss_event[0] && clk_en |-> ##2 signal_loss_flag[0]; endproperty
    a_load0: assert property (p_load0) else $error("input 0 flag not raised");
    property p_load1; loss_event[1] && clk_en |-> ##2 signal_loss_flag[1]; endproperty
    a_load1: assert property (p_load1) else $error("input 1 flag not raised");
    // Shortest count is two periods, so the flag cannot drop at once
    property p_hold0; loss_event[0] && clk_en |-> ##3 signal_loss_flag[0] [*3]; endproperty
    a_hold0: assert property (p_hold0) else $error("flag cleared too soon");
    // Flag 0 only rises as the answer to a loss event on input 0
    property p_rise0; $rose(signal_loss_flag[0]) |-> $past(loss_event[0], 2); endproperty
    a_rise0: assert property (p_rise0) else $error("flag rose without loss");
    // A pending loss wins over a completing countdown
    property p_fall0; $fell(signal_loss_flag[0]) |-> !$past(loss_event[0], 2); endproperty
    a_fall0: assert property (p_fall0) else $error("flag fell despite loss");
    // Status read reports the same flags as the pins
    property p_stat; reg_rd && reg_addr == STATUS_OFFSET |=> reg_rdata_q[1:0] == signal_loss_flag;
    endproperty
    a_stat: assert property (p_stat) else $error("status flags differ from pins");
    // Read data stand one cycle only
    property p_idle; !reg_rd |=> reg_rdata_q == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("read data without a read");
    // Unmapped places read as zero
    property p_unmap; reg_rd && reg_addr > COUNT1_OFFSET |=> reg_rdata_q == 8'h00; endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
endmodule
`default_nettype wire

// ===== hdl/ref_input_revalidation.sv
// Top of the two-input reference re-validation block with its register port
//
// Contract
// - Two-bit select gives 2, 16, 32 or 64 periods to re-validate.
// - Periods are counted after the input divider, so count scales with ratio.
// - Each of the two reference inputs has its own counter.
// - A loss event loads that input's counter from the select setting.
// - Each valid consecutive divided period decrements the counter by one.
// - A missing edge for one period reloads the counter and restarts.
// - Counter reaching zero marks input valid and clears its loss flag.
//
// The register addresses and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module ref_input_revalidation
    import revalidation_pkg::*;
(
    // Clock, reset, enable
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clk_en,
    // Reference input pins
    input wire logic [NUM_INPUTS-1:0] ref_clk_in,
    // Loss-of-signal events from the activity monitors
    input wire logic [NUM_INPUTS-1:0] loss_event,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata_q,
    // Status
    output logic [NUM_INPUTS-1:0] signal_loss_flag
);

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    ref_cfg_t cfg_q, cfg_d;
    logic [7:0] window_q, window_d;
    logic [DATA_W-1:0] rdata_d;
    logic [CNT_W-1:0] reload;
    logic [NUM_INPUTS-1:0] flag;
    logic [CNT_W-1:0] count [NUM_INPUTS];
    period_evt_t evt [NUM_INPUTS];

    // Writes steer the divider, the count and the watchdog window
    always_comb begin
        cfg_d = cfg_q;
        window_d = window_q;
        if (reg_wr && reg_addr == CONFIG_OFFSET) begin
            cfg_d.count_sel = reg_wdata[COUNT_SEL_LSB +: 2];
            cfg_d.div_sel = reg_wdata[DIV_SEL_LSB +: 2];
        end
        if (reg_wr && reg_addr == WINDOW_OFFSET) begin
            window_d = reg_wdata;
        end
        // Read data stand only in the cycle after the strobe
        rdata_d = '0;
        if (reg_rd) begin
            unique case (reg_addr)
                CONFIG_OFFSET: begin
                    rdata_d[COUNT_SEL_LSB +: 2] = cfg_q.count_sel;
                    rdata_d[DIV_SEL_LSB +: 2] = cfg_q.div_sel;
                end
                WINDOW_OFFSET: rdata_d = window_q;
                STATUS_OFFSET: begin
                    rdata_d[FLAG_LSB +: NUM_INPUTS] = flag;
                    rdata_d[BUSY_LSB +: NUM_INPUTS] = flag & ~loss_event;
                end
                COUNT0_OFFSET: rdata_d = {1'b0, count[0]};
                COUNT1_OFFSET: rdata_d = {1'b0, count[1]};
                default: rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cfg_q.count_sel <= COUNT_SEL_RESET;
            cfg_q.div_sel <= DIV_SEL_RESET;
            window_q <= WINDOW_RESET;
            reg_rdata_q <= '0;
            signal_loss_flag <= '0;
        end else if (clk_en) begin
            cfg_q <= cfg_d;
            window_q <= window_d;
            reg_rdata_q <= rdata_d;
            signal_loss_flag <= flag;
        end
    end

    // Count chosen by the select code
    assign reload = count_from_select(cfg_q.count_sel);

    // ------------------------------------------------------------------
    // Per-input monitor and counter
    // ------------------------------------------------------------------
    // Counters are independent so one input re-validates while the other holds
    for (genvar i = 0; i < NUM_INPUTS; i++) begin : g_input
        ref_period_monitor u_monitor (
            .clock(clock),
            .sys_rst(sys_rst),
            .clk_en(clk_en),
            .ref_pin(ref_clk_in[i]),
            .div_sel(cfg_q.div_sel),
            .window(window_q),
            .evt_q(evt[i])
        );
        revalidation_counter u_counter (
            .clock(clock),
            .sys_rst(sys_rst),
            .clk_en(clk_en),
            .loss_event(loss_event[i]),
            .evt(evt[i]),
            .reload(reload),
            .flag_q(flag[i]),
            .count_q(count[i])
        );
    end

endmodule
`default_nettype wire

// ===== hdl/ref_period_monitor.sv
// Synchroniser, input divider and missing-edge watchdog for one reference input
`timescale 1ns/10ps
`default_nettype none
module ref_period_monitor
    import revalidation_pkg::*;
(
    // Clock and control
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clk_en,
    // Reference pin and settings
    input wire logic ref_pin,
    input wire logic [1:0] div_sel,
    input wire logic [7:0] window,
    // Events
    output period_evt_t evt_q
);

    logic sync1_q, sync2_q, sync3_q;
    logic sync1_d, sync2_d, sync3_d;
    logic [DIV_W-1:0] div_q, div_d;
    logic [7:0] gap_q, gap_d;
    period_evt_t evt_d;
    logic rise;
    logic div_wrap;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    // Only sync2 onward is examined, the first stage may be metastable
    always_comb begin
        sync1_d = ref_pin;
        sync2_d = sync1_q;
        sync3_d = sync2_q;
        rise = sync2_q & ~sync3_q;
        // Divider wraps after 2^div_sel input rises
        div_wrap = rise && (div_q == DIV_W'((1 << div_sel) - 1));
        div_d = div_q;
        if (rise) begin
            div_d = div_wrap ? '0 : div_q + 1'b1;
        end
        evt_d = '0;
        gap_d = gap_q + 1'b1;
        if (div_wrap) begin
            evt_d.period_ok = 1'b1;
            gap_d = '0;
        end else if (gap_q >= window) begin
            // A full window of clock cycles without a divided edge: report and rearm
            evt_d.edge_missing = 1'b1;
            gap_d = '0;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            sync3_q <= 1'b0;
            div_q <= '0;
            gap_q <= '0;
            evt_q <= '0;
        end else if (clk_en) begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
            sync3_q <= sync3_d;
            div_q <= div_d;
            gap_q <= gap_d;
            evt_q <= evt_d;
        end
    end

endmodule
`default_nettype wire

// ===== hdl/revalidation_counter.sv
// Down-counter and loss flag for one reference input
`timescale 1ns/10ps
`default_nettype none
module revalidation_counter
    import revalidation_pkg::*;
(
    // Clock and control
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic clk_en,
    // Events and setting
    input wire logic loss_event,
    input wire period_evt_t evt,
    input wire logic [CNT_W-1:0] reload,
    // State
    output logic flag_q,
    output logic [CNT_W-1:0] count_q
);

    logic flag_d;
    logic [CNT_W-1:0] count_d;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    // A loss event outranks everything, so a set never loses to a clear
    always_comb begin
        flag_d = flag_q;
        count_d = count_q;
        if (loss_event) begin
            flag_d = 1'b1;
            count_d = reload;
        end else if (flag_q) begin
            if (evt.edge_missing) begin
                count_d = reload;
            end else if (evt.period_ok) begin
                count_d = count_q - COUNT_ONE;
                if (count_q == COUNT_ONE) begin
                    flag_d = 1'b0;
                end
            end
        end
        // Idle while the flag is clear: count holds its last value
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            flag_q <= 1'b0;
            count_q <= COUNT_ZERO;
        end else if (clk_en) begin
            flag_q <= flag_d;
            count_q <= count_d;
        end
    end

endmodule
`default_nettype wire

// ===== hdl/revalidation_pkg.sv
// Package with register map, field layout and counts for reference re-validation
package revalidation_pkg;

    // ------------------------------------------------------------------
    // Register bus geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] CONFIG_OFFSET = 4'h0;
    localparam logic [ADDR_W-1:0] WINDOW_OFFSET = 4'h1;
    localparam logic [ADDR_W-1:0] STATUS_OFFSET = 4'h2;
    localparam logic [ADDR_W-1:0] COUNT0_OFFSET = 4'h3;
    localparam logic [ADDR_W-1:0] COUNT1_OFFSET = 4'h4;

    // ------------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------------
    localparam int COUNT_SEL_LSB = 0;
    localparam int DIV_SEL_LSB = 2;
    localparam int FLAG_LSB = 0;
    localparam int BUSY_LSB = 2;
    localparam logic [1:0] COUNT_SEL_RESET = 2'h0;
    localparam logic [1:0] DIV_SEL_RESET = 2'h0;
    localparam logic [7:0] WINDOW_RESET = 8'h40;

    // ------------------------------------------------------------------
    // Counter geometry and programmable period counts
    // ------------------------------------------------------------------
    localparam int NUM_INPUTS = 2;
    localparam int CNT_W = 7;
    localparam logic [CNT_W-1:0] COUNT_CODE0 = 7'h02;
    localparam logic [CNT_W-1:0] COUNT_CODE1 = 7'h10;
    localparam logic [CNT_W-1:0] COUNT_CODE2 = 7'h20;
    localparam logic [CNT_W-1:0] COUNT_CODE3 = 7'h40;
    localparam logic [CNT_W-1:0] COUNT_ONE = 7'h01;
    localparam logic [CNT_W-1:0] COUNT_ZERO = 7'h00;
    localparam int DIV_W = 3;

    // Configuration carried from the register file to the monitors (divider) and the counters (count select)
    typedef struct packed {
        logic [1:0] div_sel;
        logic [1:0] count_sel;
    } ref_cfg_t;

    // Per-input period events from a monitor
    typedef struct packed {
        logic period_ok;
        logic edge_missing;
    } period_evt_t;

    // Periods needed to re-validate, counted after the divider
    function automatic logic [CNT_W-1:0] count_from_select(input logic [1:0] sel);
        logic [CNT_W-1:0] r;
        unique case (sel)
            2'h0: r = COUNT_CODE0;
            2'h1: r = COUNT_CODE1;
            2'h2: r = COUNT_CODE2;
            2'h3: r = COUNT_CODE3;
        endcase
        return r;
    endfunction

endpackage
